// >>> fbs_pkg.sv
// What this block does
// R1 - Controller strobe with primary enable high, or a disabled start, deselects and floats lanes.
// R2 - Processor strobe with chip enabled begins a read at the external address, writes ignored.
// R3 - Controller strobe alone with chip enabled begins a burst, write if decoded, else read.
// R4 - No new cycle and advance asserted: step burst address, continue read or write.
// R5 - No new cycle and advance negated: hold burst address, repeat read or write.
// R6 - Any write cycle keeps data lanes floating regardless of output enable.
// R7 - Continued or suspended reads drive lanes while output enable low, float otherwise.
// R8 - Output enable is asynchronous, never clocked, and turns drivers on directly.
// R9 - Host negates output enable before a write after a read, until it completes.
// R10 - The cycle that begins a read from deselect keeps data lanes floating.
// R11 - Linear order counts the two low address bits upward modulo four.
// R12 - Interleaved order XORs the start's low bits with 01, 10 and 11.
// R13 - Write when global write low, or write enable low with any byte select low.
// R14 - Global write low writes all four lanes, ignoring write enable and byte selects.
// R15 - Otherwise write enable low writes only selected lanes; none selected means read.
// R16 - Byte-select-only systems tie global write high and write enable low.
// R17 - The low expansion enable is active low and must be low to start a cycle.
// R18 - With primary enable high the processor strobe is ignored entirely.
// R19 - Each byte select governs its own 9-bit lane, a to d of the word.
// R20 - Address, write data and controls are registered on the rising clock edge.
// R21 - Host holds burst order select static; it is neither registered nor latched.
// R22 - The burst counter wraps within its four-word block, upper address unchanged.
package fbs_pkg;

  // ----------------------------------------------------------------------
  // Word and address layout
  // ----------------------------------------------------------------------
  localparam int ADDR_W     = 17;
  localparam int LANES      = 4;
  localparam int LANE_W     = 9;
  localparam int DATA_W     = LANES * LANE_W;
  localparam int BURST_W    = 2;

  localparam logic [BURST_W-1:0] BURST_STEP   = 2'h1;
  localparam logic [BURST_W-1:0] BURST_ZERO   = 2'h0;
  localparam logic [BURST_W-1:0] BURST_LAST   = 2'h3;
  localparam logic [LANES-1:0]   LANES_ALL    = 4'hf;
  localparam logic [LANES-1:0]   LANES_NONE   = 4'h0;
  localparam logic               ORDER_LINEAR = 1'b0;

  // ----------------------------------------------------------------------
  // State types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    CYC_DESELECT,
    CYC_READ,
    CYC_WRITE
  } fbs_cycle_t;

  typedef struct packed {
    fbs_cycle_t              kind;
    logic [ADDR_W-1:BURST_W] addr_hi;
    logic [LANES-1:0]        byte_wr;
    logic [DATA_W-1:0]       wdata;
  } fbs_ctrl_state_t;

  typedef struct packed {
    logic [BURST_W-1:0] start;
    logic [BURST_W-1:0] count;
  } fbs_burst_state_t;

endpackage

// >>> fbs_burst_if.sv
`timescale 1ns/1ps
`default_nettype none

// --------------------------------------------------------------------------
// Burst counter link between the cycle controller and the counter
// --------------------------------------------------------------------------
interface fbs_burst_if;
  logic                        load;
  logic [fbs_pkg::BURST_W-1:0] load_value;
  logic                        advance;
  logic                        order;
  logic [fbs_pkg::BURST_W-1:0] low_addr;

  modport ctrl (
    output load,
    output load_value,
    output advance,
    output order,
    input  low_addr
  );

  modport counter (
    input  load,
    input  load_value,
    input  advance,
    input  order,
    output low_addr
  );
endinterface // fbs_burst_if

`default_nettype wire

// >>> fbs_burst_counter.sv
`timescale 1ns/1ps
`default_nettype none

module fbs_burst_counter (
  input  wire logic          clk,
  input  wire logic          sys_rst,
  fbs_burst_if.counter       bus
);

  fbs_pkg::fbs_burst_state_t st;
  fbs_pkg::fbs_burst_state_t next_st;

  // --------------------------------------------------------------------------
  // Next state: a load restarts the block, an advance steps the count.
  // --------------------------------------------------------------------------
  always_comb begin
    next_st = st;
    if (bus.load) begin
      next_st.start = bus.load_value;
      next_st.count = fbs_pkg::BURST_ZERO;
    end else if (bus.advance) begin
      // The two-bit count rolls over by itself, so the burst stays in its block.
      next_st.count = st.count + fbs_pkg::BURST_STEP; // see R22
    end
  end

  // Single register stage for the whole counter state.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Order select is used live because the host keeps it static.
  assign bus.low_addr = (bus.order == fbs_pkg::ORDER_LINEAR)
                      ? st.start + st.count  // see R11
                      : st.start ^ st.count; // see R12

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  sequence s_load_linear;
    bus.load && !bus.order;
  endsequence

  sequence s_load_interleaved;
    bus.load && bus.order;
  endsequence

  property p_linear_step;
    @(posedge clk) disable iff (sys_rst)
      (bus.advance && !bus.load && !bus.order)
      |=> (bus.low_addr == $past(bus.low_addr) + fbs_pkg::BURST_STEP);
  endproperty
  a_linear_step: assert property (p_linear_step) else $error("linear step wrong"); // see R11

  property p_linear_wrap;
    @(posedge clk) disable iff (sys_rst)
      s_load_linear ##1 (bus.advance && !bus.load && !bus.order)[*4]
      |=> (bus.low_addr == $past(bus.load_value, 5));
  endproperty
  a_linear_wrap: assert property (p_linear_wrap) else $error("burst did not wrap"); // see R22

  property p_interleave_last;
    @(posedge clk) disable iff (sys_rst)
      s_load_interleaved ##1 (bus.advance && !bus.load && bus.order)[*3]
      |=> (bus.low_addr == ($past(bus.load_value, 4) ^ fbs_pkg::BURST_LAST));
  endproperty
  a_interleave_last: assert property (p_interleave_last) else $error("interleave wrong"); // see R12

  property p_load_first;
    @(posedge clk) disable iff (sys_rst)
      bus.load |=> (bus.low_addr == $past(bus.load_value));
  endproperty
  a_load_first: assert property (p_load_first) else $error("first address wrong"); // see R11

endmodule // fbs_burst_counter

`default_nettype wire

// >>> fbs_sram_control.sv
`timescale 1ns/1ps
`default_nettype none

module fbs_sram_control (
  input  wire logic                         clk,
  input  wire logic                         sys_rst,
  input  wire logic [fbs_pkg::ADDR_W-1:0]   address_inputs,
  input  wire logic                         processor_address_strobe_n,
  input  wire logic                         controller_address_strobe_n,
  input  wire logic                         burst_advance_n,
  input  wire logic                         chip_enable_primary_n,
  input  wire logic                         chip_enable_high_expand,
  input  wire logic                         chip_enable_low_expand_n,
  input  wire logic                         all_byte_write_n,
  input  wire logic                         write_select_enable_n,
  input  wire logic [fbs_pkg::LANES-1:0]    byte_write_select_n,
  input  wire logic                         burst_order_select,
  input  wire logic                         output_enable_n,
  input  wire logic [fbs_pkg::DATA_W-1:0]   data_lanes_in,
  output logic      [fbs_pkg::DATA_W-1:0]   data_lanes_out,
  output logic      [fbs_pkg::LANES-1:0]    data_lanes_oe,
  output logic      [fbs_pkg::ADDR_W-1:0]   mem_addr,
  output logic                              mem_read_enable,
  output logic      [fbs_pkg::LANES-1:0]    mem_byte_write,
  output logic      [fbs_pkg::DATA_W-1:0]   mem_write_data,
  input  wire logic [fbs_pkg::DATA_W-1:0]   mem_read_data
);

  // --------------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------------
  fbs_pkg::fbs_ctrl_state_t st;
  fbs_pkg::fbs_ctrl_state_t next_st;

  fbs_burst_if bl ();

  logic                       chip_selected;
  logic                       proc_start;
  logic                       ctrl_start;
  logic                       new_cycle;
  logic [fbs_pkg::LANES-1:0]  wr_mask;
  logic                       wr_any;
  logic                       read_drive;

  // --------------------------------------------------------------------------
  // Burst counter
  // --------------------------------------------------------------------------
  fbs_burst_counter u_counter (
    .clk     (clk),
    .sys_rst (sys_rst),
    .bus     (bl)
  );

  // --------------------------------------------------------------------------
  // Input decode
  // --------------------------------------------------------------------------

  // All three enables must agree before any cycle may start.
  assign chip_selected = !chip_enable_primary_n
                       && chip_enable_high_expand
                       && !chip_enable_low_expand_n;          // see R17

  // The processor strobe counts only while the primary enable is low.
  assign proc_start = !processor_address_strobe_n && !chip_enable_primary_n; // see R18
  assign ctrl_start = !controller_address_strobe_n && !proc_start;
  assign new_cycle  = proc_start || !controller_address_strobe_n;

  // Per-lane write decode; global write overrides the byte selects.
  generate
    for (genvar i = 0; i < fbs_pkg::LANES; i++) begin : g_lane
      assign wr_mask[i] = !all_byte_write_n                                // see R14
                        || (!write_select_enable_n && !byte_write_select_n[i]); // see R15
    end
  endgenerate

  // A write needs at least one lane selected; otherwise it is a read.
  assign wr_any = |wr_mask; // see R13

  // --------------------------------------------------------------------------
  // Cycle controller next state
  // --------------------------------------------------------------------------
  always_comb begin
    next_st        = st;
    bl.load        = 1'b0;
    bl.advance     = 1'b0;
    bl.load_value  = address_inputs[fbs_pkg::BURST_W-1:0];
    bl.order       = burst_order_select;
    // Write data is sampled every edge; it matters only in write cycles.
    next_st.wdata  = data_lanes_in;                               // see R20
    if (proc_start) begin
      if (chip_selected) begin
        // Write controls are not looked at on a processor start.
        next_st.kind    = fbs_pkg::CYC_READ;                      // see R2
        next_st.addr_hi = address_inputs[fbs_pkg::ADDR_W-1:fbs_pkg::BURST_W];
        next_st.byte_wr = fbs_pkg::LANES_NONE;
        bl.load         = 1'b1;
      end else begin
        next_st.kind    = fbs_pkg::CYC_DESELECT;                  // see R1
        next_st.byte_wr = fbs_pkg::LANES_NONE;
      end
    end else if (ctrl_start) begin
      if (chip_selected) begin
        next_st.kind    = wr_any ? fbs_pkg::CYC_WRITE : fbs_pkg::CYC_READ; // see R3
        next_st.addr_hi = address_inputs[fbs_pkg::ADDR_W-1:fbs_pkg::BURST_W];
        next_st.byte_wr = wr_any ? wr_mask : fbs_pkg::LANES_NONE;
        bl.load         = 1'b1;
      end else begin
        next_st.kind    = fbs_pkg::CYC_DESELECT;                  // see R1
        next_st.byte_wr = fbs_pkg::LANES_NONE;
      end
    end else if (st.kind != fbs_pkg::CYC_DESELECT) begin
      // No new cycle: advance low steps the burst, high repeats the address.
      bl.advance = !burst_advance_n;                              // see R4 R5
      if (st.kind == fbs_pkg::CYC_WRITE) begin
        // Lanes are resampled so each beat may pick its own bytes.
        next_st.byte_wr = wr_mask;                                // see R15
      end
    end
  end

  // One register stage for all controller state.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;                                              // see R20
    end
  end

  // --------------------------------------------------------------------------
  // Array side and data lanes
  // --------------------------------------------------------------------------

  // Upper bits stay as captured; only the counter moves the low two.
  assign mem_addr        = {st.addr_hi, bl.low_addr};             // see R22
  assign mem_read_enable = (st.kind == fbs_pkg::CYC_READ);
  assign mem_write_data  = st.wdata;                              // see R19
  assign mem_byte_write  = (st.kind == fbs_pkg::CYC_WRITE) ? st.byte_wr
                                                           : fbs_pkg::LANES_NONE;

  // Flow-through: read data passes straight from the array to the lanes.
  assign data_lanes_out = mem_read_data;

  // Output enable is not clocked, so the drivers follow it within the cycle.
  // Write and deselect states never drive, which also covers the first
  // cycle of a read started from deselect.
  assign read_drive    = (st.kind == fbs_pkg::CYC_READ) && !output_enable_n; // see R8 R6 R10
  assign data_lanes_oe = {fbs_pkg::LANES{read_drive}};            // see R7

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  sequence s_no_new_cycle;
    controller_address_strobe_n
    && (processor_address_strobe_n || chip_enable_primary_n);
  endsequence

  sequence s_proc_begin;
    !processor_address_strobe_n && !chip_enable_primary_n
    && chip_enable_high_expand && !chip_enable_low_expand_n;
  endsequence

  sequence s_ctrl_begin_write;
    processor_address_strobe_n && !controller_address_strobe_n
    && !chip_enable_primary_n && chip_enable_high_expand
    && !chip_enable_low_expand_n && !all_byte_write_n;
  endsequence

  property p_desel_ctrl;
    (!controller_address_strobe_n && chip_enable_primary_n)
    |=> (st.kind == fbs_pkg::CYC_DESELECT) && (data_lanes_oe == fbs_pkg::LANES_NONE);
  endproperty
  a_desel_ctrl: assert property (p_desel_ctrl) else $error("no deselect"); // see R1

  property p_desel_expand;
    (new_cycle && chip_enable_low_expand_n) |=> (st.kind == fbs_pkg::CYC_DESELECT);
  endproperty
  a_desel_expand: assert property (p_desel_expand) else $error("expand ignored"); // see R17

  property p_proc_read;
    s_proc_begin
    |=> (st.kind == fbs_pkg::CYC_READ) && (mem_byte_write == fbs_pkg::LANES_NONE)
        && (mem_addr == $past(address_inputs));
  endproperty
  a_proc_read: assert property (p_proc_read) else $error("processor read wrong"); // see R2

  property p_global_write;
    s_ctrl_begin_write
    |=> (st.kind == fbs_pkg::CYC_WRITE) && (mem_byte_write == fbs_pkg::LANES_ALL)
        && (mem_write_data == $past(data_lanes_in));
  endproperty
  a_global_write: assert property (p_global_write) else $error("global write wrong"); // see R14

  property p_ctrl_kind;
    (processor_address_strobe_n && !controller_address_strobe_n && chip_selected)
    |=> (st.kind == (($past(!all_byte_write_n)
                      || ($past(!write_select_enable_n)
                          && ($past(byte_write_select_n) != fbs_pkg::LANES_ALL)))
                     ? fbs_pkg::CYC_WRITE : fbs_pkg::CYC_READ));
  endproperty
  a_ctrl_kind: assert property (p_ctrl_kind) else $error("burst kind wrong"); // see R3

  property p_byte_lanes;
    (st.kind == fbs_pkg::CYC_WRITE) && all_byte_write_n && !write_select_enable_n
    and s_no_new_cycle |=> (mem_byte_write == ~$past(byte_write_select_n));
  endproperty
  a_byte_lanes: assert property (p_byte_lanes) else $error("byte lanes wrong"); // see R15

  property p_continue;
    (st.kind != fbs_pkg::CYC_DESELECT) and s_no_new_cycle and !burst_advance_n
    |=> (st.kind == $past(st.kind))
        && (mem_addr[fbs_pkg::BURST_W-1:0] != $past(mem_addr[fbs_pkg::BURST_W-1:0]))
        && (mem_addr[fbs_pkg::ADDR_W-1:fbs_pkg::BURST_W]
            == $past(mem_addr[fbs_pkg::ADDR_W-1:fbs_pkg::BURST_W]));
  endproperty
  a_continue: assert property (p_continue) else $error("continue wrong"); // see R4

  property p_suspend;
    (st.kind != fbs_pkg::CYC_DESELECT) and s_no_new_cycle and burst_advance_n
    |=> (st.kind == $past(st.kind)) && (mem_addr == $past(mem_addr));
  endproperty
  a_suspend: assert property (p_suspend) else $error("suspend moved address"); // see R5

  property p_write_float;
    (st.kind == fbs_pkg::CYC_WRITE) |-> (data_lanes_oe == fbs_pkg::LANES_NONE);
  endproperty
  a_write_float: assert property (p_write_float) else $error("write drove lanes"); // see R6

  property p_read_drive;
    (st.kind == fbs_pkg::CYC_READ)
    |-> (data_lanes_oe == (output_enable_n ? fbs_pkg::LANES_NONE : fbs_pkg::LANES_ALL));
  endproperty
  a_read_drive: assert property (p_read_drive) else $error("read drive wrong"); // see R7

  property p_begin_float;
    (st.kind == fbs_pkg::CYC_DESELECT) ##0 s_proc_begin
    |-> (data_lanes_oe == fbs_pkg::LANES_NONE) ##1 (st.kind == fbs_pkg::CYC_READ);
  endproperty
  a_begin_float: assert property (p_begin_float) else $error("begin read drove"); // see R10

endmodule // fbs_sram_control

`default_nettype wire

// >>> fbs_array_model.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------
// Storage array on the far side of the controller
// ----------------------------------------------------------------------
module fbs_array_model (
  input  wire logic        clk,
  input  wire logic [16:0] mem_addr,
  input  wire logic        mem_read_enable,
  input  wire logic [3:0]  mem_byte_write,
  input  wire logic [35:0] mem_write_data,
  output logic      [35:0] mem_read_data
);
  logic [35:0] arr [logic [16:0]];
  logic [35:0] last = 36'h0_0000_0000;
  logic        wr_tick = 1'b0;

  // Flow-through read; when released the bus shows the inverse of its last word.
  // The tick re-runs the read after a write, as the array itself is not watched.
  always @(mem_addr, mem_read_enable, wr_tick) begin
    if (!mem_read_enable) mem_read_data = ~last;
    else if (arr.exists(mem_addr)) mem_read_data = arr[mem_addr];
    else mem_read_data = 'x;
  end

  // Each lane strobe commits only its own 9 bits at the closing edge.
  always @(posedge clk) begin
    if (mem_read_enable) last <= mem_read_data;
    if (mem_byte_write != 4'h0) begin
      if (!arr.exists(mem_addr)) arr[mem_addr] = 'x;
      for (int i = 0; i < 4; i++) begin
        if (mem_byte_write[i]) arr[mem_addr][i*9 +: 9] = mem_write_data[i*9 +: 9];
      end
      wr_tick <= ~wr_tick;
    end
  end
endmodule // fbs_array_model

`default_nettype wire

// >>> tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb;
  localparam logic [2:0] ON = 3'h2;
  typedef struct {
    fbs_pkg::fbs_cycle_t kind;
    logic [16:0]         addr;
    logic [3:0]          bw;
    logic [35:0]         dat;
  } fbs_note_t;

  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [16:0] address_inputs = 17'h0_0000;
  logic        processor_address_strobe_n = 1'b1;
  logic        controller_address_strobe_n = 1'b1;
  logic        burst_advance_n = 1'b1;
  logic        chip_enable_primary_n = 1'b1;
  logic        chip_enable_high_expand = 1'b1;
  logic        chip_enable_low_expand_n = 1'b0;
  logic        all_byte_write_n = 1'b1;
  logic        write_select_enable_n = 1'b1;
  logic [3:0]  byte_write_select_n = 4'hf;
  logic        burst_order_select = 1'b0;
  logic        output_enable_n = 1'b1;
  logic [35:0] data_lanes_in = 36'h0_0000_0000;
  logic [35:0] data_lanes_out, mem_write_data, mem_read_data;
  logic [3:0]  data_lanes_oe, mem_byte_write;
  logic [16:0] mem_addr, a;
  logic        mem_read_enable, rd, wr, ord;
  int          seed = 11661;
  int          num_errors = 0;
  int          compares = 0;
  logic [31:0] r;
  fbs_pkg::fbs_cycle_t kind = fbs_pkg::CYC_DESELECT;
  logic [16:0] base;
  logic [1:0]  cnt;
  logic [35:0] sh [logic [16:0]];
  fbs_note_t   pend[$], armed[$], n;
  logic [4:0]  bt [7] = '{5'h0e, 5'h0d, 5'h0b, 5'h07, 5'h00, 5'h0f, 5'h10};
  logic [4:0]  dt [6] = '{5'h16, 5'h0b, 5'h08, 5'h13, 5'h10, 5'h0e};

  fbs_sram_control dut (.clk, .sys_rst, .address_inputs, .processor_address_strobe_n,
    .controller_address_strobe_n, .burst_advance_n, .chip_enable_primary_n,
    .chip_enable_high_expand, .chip_enable_low_expand_n, .all_byte_write_n,
    .write_select_enable_n, .byte_write_select_n, .burst_order_select, .output_enable_n,
    .data_lanes_in, .data_lanes_out, .data_lanes_oe, .mem_addr, .mem_read_enable,
    .mem_byte_write, .mem_write_data, .mem_read_data);

  fbs_array_model array (.clk, .mem_addr, .mem_read_enable, .mem_byte_write,
    .mem_write_data, .mem_read_data);

  // 200 MHz clock.
  always #2.5 clk = ~clk;

  // ----------------------------------------------------------------------
  // Shared helpers
  // ----------------------------------------------------------------------
  task automatic chk(input string what, input logic [35:0] exp, input logic [35:0] got);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  function automatic logic [35:0] rnd36();
    return 36'({$random(seed), $random(seed)});
  endfunction

  // One clock of host activity; the expected outcome is worked out and queued.
  task automatic beat(input logic ps, cs, burst_advance, input logic [2:0] ce, input logic gw, we,
                      input logic [3:0] bs, input logic oe, input logic [16:0] ad,
                      input logic [35:0] d);
    fbs_note_t  e;
    logic [3:0] dec;
    @(posedge clk);
    processor_address_strobe_n <= ps;
    controller_address_strobe_n <= cs;
    burst_advance_n <= burst_advance;
    {chip_enable_primary_n, chip_enable_high_expand, chip_enable_low_expand_n} <= ce;
    all_byte_write_n <= gw;
    write_select_enable_n <= we;
    byte_write_select_n <= bs;
    output_enable_n <= oe;
    address_inputs <= ad;
    data_lanes_in <= d;
    dec = !gw ? 4'hf : (!we ? ~bs : 4'h0);
    if (!ps && !ce[2]) begin
      kind = (ce == ON) ? fbs_pkg::CYC_READ : fbs_pkg::CYC_DESELECT;
      base = ad;
      cnt = 2'h0;
    end else if (!cs) begin
      kind = (ce != ON) ? fbs_pkg::CYC_DESELECT :
             (dec != 4'h0) ? fbs_pkg::CYC_WRITE : fbs_pkg::CYC_READ;
      base = ad;
      cnt = 2'h0;
    end else if (kind != fbs_pkg::CYC_DESELECT && !burst_advance) begin
      cnt = cnt + 2'h1;
    end
    e.kind = kind;
    e.bw = dec;
    e.addr = {base[16:2], ord ? base[1:0] ^ cnt : base[1:0] + cnt};
    if (kind == fbs_pkg::CYC_WRITE) begin
      if (!sh.exists(e.addr)) sh[e.addr] = 'x;
      for (int i = 0; i < 4; i++) if (dec[i]) sh[e.addr][i*9 +: 9] = d[i*9 +: 9];
    end
    e.dat = (kind == fbs_pkg::CYC_WRITE) ? d : (sh.exists(e.addr) ? sh[e.addr] : 'x);
    pend.push_back(e);
  endtask

  // Deselect with the output enable negated, as a write may follow.
  task automatic desel();
    beat(1, 0, 1, 3'h6, 1, 1, 4'hf, 1, 17'($random(seed)), rnd36());
  endtask

  task automatic give_verdict();
    $display("compares %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Watcher: a note queued at one edge is due in the cycle after the next
  // ----------------------------------------------------------------------
  always @(negedge clk) begin
    if (armed.size() > 0) begin
      n = armed.pop_front();
      rd = (n.kind == fbs_pkg::CYC_READ);
      wr = (n.kind == fbs_pkg::CYC_WRITE);
      chk("mem_read_enable", 36'(rd), 36'(mem_read_enable));
      chk("mem_byte_write", 36'(wr ? n.bw : 4'h0), 36'(mem_byte_write));
      chk("data_lanes_oe", 36'((rd && !output_enable_n) ? 4'hf : 4'h0), 36'(data_lanes_oe));
      if (n.kind != fbs_pkg::CYC_DESELECT) chk("mem_addr", 36'(n.addr), 36'(mem_addr));
      if (rd) chk("data_lanes_out", n.dat, data_lanes_out);
      if (wr) chk("mem_write_data", n.dat, mem_write_data);
    end
    while (pend.size() > 0) armed.push_back(pend.pop_front());
  end

  // Watchdog sized well beyond the roughly 450 cycles of traffic.
  initial begin
    #50000;
    num_errors++;
    give_verdict();
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    ord = 1'b0;
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    // Whole-word bursts from every start, linear then interleaved order.
    for (int o = 0; o < 2; o++) begin
      desel();
      ord = o[0];
      burst_order_select <= ord;
      for (int s = 0; s < 4; s++) begin
        a = 17'($random(seed));
        a[1:0] = s[1:0];
        beat(1, 0, 1, ON, 0, 1, 4'hf, 1, a, rnd36());
        repeat (3) beat(1, 1, 0, ON, 0, 1, 4'hf, 1, 17'($random(seed)), rnd36());
        beat(1, 1, 1, ON, 0, 1, 4'hf, 0, a, rnd36());
        desel();
        beat(0, 1, 1, ON, 0, 0, 4'h0, 0, a, rnd36());
        repeat (4) beat(1, 1, 0, ON, 1, 1, 4'hf, 1'($random(seed)), a, rnd36());
        beat(1, 1, 1, ON, 1, 1, 4'hf, 0, a, rnd36());
      end
      $display("test burst order %0d done", o);
    end
    // Lane-selective writes and two no-lane decodes that read, each read back.
    a = 17'($random(seed));
    beat(1, 0, 1, ON, 0, 1, 4'hf, 1, a, rnd36());
    for (int j = 0; j < 7; j++) begin
      beat(1, 0, 1, ON, 1, bt[j][4], bt[j][3:0], 1, a, rnd36());
      desel();
      beat(0, 1, 1, ON, 1, 1, 4'hf, 0, a, rnd36());
      beat(1, 1, 1, ON, 1, 1, 4'hf, 0, a, rnd36());
    end
    $display("test byte lanes done");
    // Deselect decodes and the ignored processor strobe, each from a read.
    for (int j = 0; j < 6; j++) begin
      beat(0, 1, 1, ON, 1, 1, 4'hf, 0, a, rnd36());
      beat(dt[j][4], dt[j][3], 0, dt[j][2:0], 1, 1, 4'hf, 0, a, rnd36());
      beat(1, 1, 0, ON, 1, 1, 4'hf, 0, a, rnd36());
    end
    $display("test deselect done");
    // Random traffic with the output enable kept negated.
    for (int i = 0; i < 300; i++) begin
      r = $random(seed);
      beat(r[0] | r[1], r[2], r[3], r[7] ? ON : r[6:4], r[8] | r[9], r[10], r[14:11], 1,
           {r[31:17], r[16:15]}, rnd36());
    end
    desel();
    repeat (2) @(posedge clk);
    $display("test random done");
    give_verdict();
  end
endmodule // tb

`default_nettype wire
